// [rtl/asr_pkg.sv]
package asr_pkg;

  // Memory geometry and timer width
  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;
  localparam int TMR_W  = 8;

  // Clock rate
  localparam int CLK_PERIOD_NS = 25;

  // Pin timing, in ns; defaults suit a slow speed grade
  localparam int READ_CYCLE_TIME_NS              = 120;
  localparam int WRITE_PULSE_TIME_NS             = 70;
  localparam int WRITE_RECOVERY_TIME_NS          = 10;
  localparam int DESELECT_TO_RETENTION_TIME_NS   = 0;
  localparam int RETENTION_EXIT_RECOVERY_TIME_NS = READ_CYCLE_TIME_NS;

  // Least times round up, never below one cycle
  localparam int READ_CYCLE_RAW  = (READ_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_PULSE_RAW = (WRITE_PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_REC_RAW   = (WRITE_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESUME_RAW      =
    (RETENTION_EXIT_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [TMR_W-1:0] READ_CYCLE_CYC  =
    TMR_W'((READ_CYCLE_RAW < 1) ? 1 : READ_CYCLE_RAW);
  localparam logic [TMR_W-1:0] WRITE_PULSE_CYC =
    TMR_W'((WRITE_PULSE_RAW < 1) ? 1 : WRITE_PULSE_RAW);
  localparam logic [TMR_W-1:0] WRITE_REC_CYC   =
    TMR_W'((WRITE_REC_RAW < 1) ? 1 : WRITE_REC_RAW);
  localparam logic [TMR_W-1:0] RESUME_CYC      =
    TMR_W'((RESUME_RAW < 1) ? 1 : RESUME_RAW);
  localparam logic [TMR_W-1:0] SETUP_CYC       = 8'h01;
  localparam logic [TMR_W-1:0] TMR_IDLE        = 8'h00;
  localparam logic [TMR_W-1:0] TMR_ONE         = 8'h01;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RD_SETUP,
    ST_RD_ACTIVE,
    ST_WR_SETUP,
    ST_WR_PULSE,
    ST_WR_RECOVER,
    ST_RETAIN,
    ST_RESUME
  } asr_state_type;

endpackage

// [rtl/asr_timer_if.sv]
interface asr_timer_if;
  logic                           load;
  logic [asr_pkg::TMR_W-1:0]      value;
  logic                           done;

  modport ctrl  (output load, output value, input done);
  modport timer (input load, input value, output done);
endinterface

// [rtl/asr_timer.sv]
module asr_timer (
  // Clock and reset
  input  wire logic  clk,
  input  wire logic  rst_n,
  // Control from sequencer
  asr_timer_if.timer tif
);

  logic [asr_pkg::TMR_W-1:0] count;

  // Load wins over the running count
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      count <= asr_pkg::TMR_IDLE;
    else if (tif.load)
      count <= tif.value;
    else if (count != asr_pkg::TMR_IDLE)
      count <= count - asr_pkg::TMR_ONE;
  end

  // Last cycle of a phase; a load of N gives exactly N cycles
  assign tif.done = (count <= asr_pkg::TMR_ONE);

endmodule

// [rtl/asr_host.sv]
module asr_host (
  // Clock and reset
  input  wire logic                        REF_CLK_IN,
  input  wire logic                        RESET_N_IN,
  // User request side
  input  wire logic                        REQ_IN,
  input  wire logic                        WRITE_IN,
  input  wire logic [asr_pkg::ADDR_W-1:0]  ADDR_IN,
  input  wire logic [asr_pkg::DATA_W-1:0]  WDATA_IN,
  output logic                             READY_OUT,
  output logic [asr_pkg::DATA_W-1:0]       RDATA_OUT,
  output logic                             RDATA_VALID_OUT,
  // Supply monitor
  input  wire logic                        SUPPLY_OK_IN,
  output logic                             RETAIN_OUT,
  // Memory pins
  output logic                             SEL_N_OUT,
  output logic                             GATE_N_OUT,
  output logic                             STROBE_N_OUT,
  output logic [asr_pkg::ADDR_W-1:0]       ADDR_OUT,
  input  wire logic [asr_pkg::DATA_W-1:0]  DATA_IN,
  output logic [asr_pkg::DATA_W-1:0]       DATA_OUT,
  output logic                             DATA_OE_OUT
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations

  asr_pkg::asr_state_type    state;
  asr_pkg::asr_state_type    next_state;
  logic [asr_pkg::TMR_W-1:0] next_tmr_value;
  logic                      accept;

  // One shared phase counter serves every timed phase
  asr_timer_if tif ();

  asr_timer u_timer (
    .clk   (REF_CLK_IN),
    .rst_n (RESET_N_IN),
    .tif   (tif.timer)
  );

  // Pin decode shared by the output flops
  function automatic logic sel_active(input asr_pkg::asr_state_type s);
    return (s == asr_pkg::ST_RD_ACTIVE) || (s == asr_pkg::ST_WR_PULSE);
  endfunction

  function automatic logic data_driven(input asr_pkg::asr_state_type s);
    return (s == asr_pkg::ST_WR_PULSE) || (s == asr_pkg::ST_WR_RECOVER);
  endfunction

  // Gate and strobe decode to disjoint phases, so never low together
  function automatic logic gate_active(input asr_pkg::asr_state_type s);
    return s == asr_pkg::ST_RD_ACTIVE;
  endfunction

  function automatic logic strobe_active(input asr_pkg::asr_state_type s);
    return s == asr_pkg::ST_WR_PULSE;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer

  // Request taken only from idle with the supply good
  assign accept = (state == asr_pkg::ST_IDLE) && REQ_IN && SUPPLY_OK_IN;

  // Next state; supply loss overrides every phase
  always_comb
  begin
    next_state = state;
    unique case (state)
      asr_pkg::ST_IDLE:
        if (accept)
          next_state = WRITE_IN ? asr_pkg::ST_WR_SETUP : asr_pkg::ST_RD_SETUP;
      asr_pkg::ST_RD_SETUP:
        next_state = asr_pkg::ST_RD_ACTIVE;
      asr_pkg::ST_RD_ACTIVE:
        if (tif.done)
          next_state = asr_pkg::ST_IDLE;
      asr_pkg::ST_WR_SETUP:
        next_state = asr_pkg::ST_WR_PULSE;
      asr_pkg::ST_WR_PULSE:
        if (tif.done)
          next_state = asr_pkg::ST_WR_RECOVER;
      asr_pkg::ST_WR_RECOVER:
        if (tif.done)
          next_state = asr_pkg::ST_IDLE;
      asr_pkg::ST_RETAIN:
        if (SUPPLY_OK_IN)
          next_state = asr_pkg::ST_RESUME;
      asr_pkg::ST_RESUME:
        if (tif.done)
          next_state = asr_pkg::ST_IDLE;
    endcase
    if (!SUPPLY_OK_IN)
      next_state = asr_pkg::ST_RETAIN;
  end

  // Phase length for the state being entered
  always_comb
  begin
    next_tmr_value = asr_pkg::SETUP_CYC;
    unique case (next_state)
      asr_pkg::ST_RD_ACTIVE:  next_tmr_value = asr_pkg::READ_CYCLE_CYC;
      asr_pkg::ST_WR_PULSE:   next_tmr_value = asr_pkg::WRITE_PULSE_CYC;
      asr_pkg::ST_WR_RECOVER: next_tmr_value = asr_pkg::WRITE_REC_CYC;
      asr_pkg::ST_RESUME:     next_tmr_value = asr_pkg::RESUME_CYC;
      default:                next_tmr_value = asr_pkg::SETUP_CYC;
    endcase
  end

  // Timer restarts on every change of phase
  assign tif.load  = (next_state != state);
  assign tif.value = next_tmr_value;

  // State register
  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
      state <= asr_pkg::ST_IDLE;
    else
      state <= next_state;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Memory control pins, registered from the next state

  // Select and write strobe fall together so memory outputs stay off
  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      SEL_N_OUT    <= 1'b1;
      GATE_N_OUT   <= 1'b1;
      STROBE_N_OUT <= 1'b1;
    end
    else
    begin
      SEL_N_OUT    <= !sel_active(next_state);
      GATE_N_OUT   <= !gate_active(next_state);
      STROBE_N_OUT <= !strobe_active(next_state);
    end
  end

  // Address moves only in idle, where strobe is already high
  // Loading it elsewhere would let a write land at a moving address
  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
      ADDR_OUT <= '0;
    else if (accept)
      ADDR_OUT <= ADDR_IN;
  end

  // Write data held through recovery for hold time; memory gate stays high
  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      DATA_OUT    <= '0;
      DATA_OE_OUT <= 1'b0;
    end
    else
    begin
      if (accept && WRITE_IN)
        DATA_OUT <= WDATA_IN;
      DATA_OE_OUT <= data_driven(next_state);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // User side

  // Read data sampled on the last cycle of the full read cycle
  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      RDATA_OUT       <= '0;
      RDATA_VALID_OUT <= 1'b0;
    end
    else
    begin
      RDATA_VALID_OUT <= 1'b0;
      if (gate_active(state) && tif.done && SUPPLY_OK_IN)
      begin
        RDATA_OUT       <= DATA_IN;
        RDATA_VALID_OUT <= 1'b1;
      end
    end
  end

  // Status flags; ready drops in the cycle a request is taken
  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      READY_OUT  <= 1'b0;
      RETAIN_OUT <= 1'b0;
    end
    else
    begin
      READY_OUT  <= (next_state == asr_pkg::ST_IDLE) && !accept;
      RETAIN_OUT <= (next_state == asr_pkg::ST_RETAIN);
    end
  end

endmodule

// [verif/asr_host_properties.sv]
module asr_host_properties (
  // Clock and reset
  input wire logic                       REF_CLK_IN,
  input wire logic                       RESET_N_IN,
  // Supply and user side
  input wire logic                       SUPPLY_OK_IN,
  input wire logic                       READY_OUT,
  input wire logic [asr_pkg::DATA_W-1:0] RDATA_OUT,
  input wire logic                       RDATA_VALID_OUT,
  input wire logic                       RETAIN_OUT,
  // Memory pins
  input wire logic                       SEL_N_OUT,
  input wire logic                       GATE_N_OUT,
  input wire logic                       STROBE_N_OUT,
  input wire logic [asr_pkg::ADDR_W-1:0] ADDR_OUT,
  input wire logic [asr_pkg::DATA_W-1:0] DATA_IN,
  input wire logic                       DATA_OE_OUT
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!RESET_N_IN);

  ////////////////////////////////////////////////////////////////
  // Pin discipline
  a_standby_quiet: assert property (SEL_N_OUT |-> GATE_N_OUT && STROBE_N_OUT)
    else $error("strobe or gate low while deselected");
  a_read_strobe_high: assert property (!GATE_N_OUT |-> STROBE_N_OUT)
    else $error("strobe low during read");
  a_no_contention: assert property (!GATE_N_OUT |-> !DATA_OE_OUT)
    else $error("host drives pins while memory drives");
  a_addr_steady: assert property ($changed(ADDR_OUT) |-> STROBE_N_OUT && $past(STROBE_N_OUT))
    else $error("address moved during write");
  a_sel_addr_setup: assert property ($fell(SEL_N_OUT) |-> $stable(ADDR_OUT))
    else $error("address moved as select fell");
  a_strobe_with_sel: assert property ($fell(STROBE_N_OUT) |-> $fell(SEL_N_OUT))
    else $error("strobe fell without select");

  ////////////////////////////////////////////////////////////////
  // Write timing; a supply abort cuts these short on purpose
  a_write_pulse: assert property (disable iff (!RESET_N_IN || !SUPPLY_OK_IN)
    $fell(STROBE_N_OUT) |-> (!STROBE_N_OUT && !SEL_N_OUT)[*3] ##1 (STROBE_N_OUT && SEL_N_OUT))
    else $error("write overlap length wrong");
  a_write_recover: assert property (disable iff (!RESET_N_IN || !SUPPLY_OK_IN)
    $rose(STROBE_N_OUT) |-> DATA_OE_OUT ##1 !DATA_OE_OUT)
    else $error("write recovery wrong");

  ////////////////////////////////////////////////////////////////
  // Read data and retention
  a_read_capture: assert property (RDATA_VALID_OUT |-> RDATA_OUT == $past(DATA_IN))
    else $error("read data not taken from pins");
  a_retain_deselect: assert property (!SUPPLY_OK_IN |=> SEL_N_OUT && RETAIN_OUT && !DATA_OE_OUT)
    else $error("not deselected on supply loss");
  a_resume_hold: assert property ($fell(RETAIN_OUT) |-> (SEL_N_OUT && !READY_OUT)[*4])
    else $error("resumed too early");

  c_read: cover property (RDATA_VALID_OUT);
  c_write: cover property ($fell(STROBE_N_OUT));
  c_retain: cover property ($rose(RETAIN_OUT));
endmodule

bind asr_host asr_host_properties asr_host_properties_inst (.*);

// [verif/asr_sram_model.sv]
module asr_sram_model (
  // Memory pins
  input  wire logic                       sel_n,
  input  wire logic                       gate_n,
  input  wire logic                       strobe_n,
  input  wire logic [asr_pkg::ADDR_W-1:0] addr,
  input  wire logic [asr_pkg::DATA_W-1:0] din,
  output logic      [asr_pkg::DATA_W-1:0] dout,
  output logic                            drive
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [2048];
  logic       wr_on = 1'b0;

  // Drive only when selected, gated and not writing
  assign drive = !sel_n && !gate_n && strobe_n;
  assign dout  = mem[addr];

  // Byte lands when the overlap ends, on whichever pin rises first
  always @(sel_n or strobe_n)
  begin
    if (wr_on && (sel_n || strobe_n))
      mem[addr] = din;
    wr_on = !sel_n && !strobe_n;
  end
endmodule

// [verif/asr_host_tb_top.sv]
module asr_host_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        req = 1'b0;
  logic        wr = 1'b0;
  logic        sup = 1'b1;
  logic [10:0] addr = 11'h000;
  logic [7:0]  wdata = 8'h00;
  logic [7:0]  float_v = 8'h5a;
  logic [7:0]  pins, rdata, dout, mem_q;
  logic [10:0] maddr;
  logic        ready, rvalid, retain, sel_n, gate_n, strobe_n, oe, mem_drive;
  logic [7:0]  shadow [int];
  int          errors = 0;
  int          checks = 0;

  // Free pins show a changing pattern, never a stale byte
  assign pins = oe ? dout : (mem_drive ? mem_q : float_v);
  always @(posedge clk) float_v <= ~float_v + 8'h01;

  initial
  begin
    forever #12.5 clk = ~clk;
  end

  asr_host asr_host_inst (.REF_CLK_IN(clk), .RESET_N_IN(rst_n), .REQ_IN(req), .WRITE_IN(wr),
    .ADDR_IN(addr), .WDATA_IN(wdata), .READY_OUT(ready), .RDATA_OUT(rdata),
    .RDATA_VALID_OUT(rvalid), .SUPPLY_OK_IN(sup), .RETAIN_OUT(retain), .SEL_N_OUT(sel_n),
    .GATE_N_OUT(gate_n), .STROBE_N_OUT(strobe_n), .ADDR_OUT(maddr), .DATA_IN(pins),
    .DATA_OUT(dout), .DATA_OE_OUT(oe));
  asr_sram_model asr_sram_model_inst (.sel_n(sel_n), .gate_n(gate_n), .strobe_n(strobe_n),
    .addr(maddr), .din(pins), .dout(mem_q), .drive(mem_drive));

  ////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Expected byte for a read: the last value written there
  function automatic logic [15:0] exp_byte(input logic [10:0] a);
    return 16'(shadow[a]);
  endfunction

  // One request; waits for idle first, then for the answer
  task automatic op(input logic w, input logic [10:0] a, input logic [7:0] d);
    int n;
    while (ready !== 1'b1) @(negedge clk);
    req = 1'b1;
    wr = w;
    addr = a;
    wdata = d;
    @(negedge clk);
    req = 1'b0;
    n = 0;
    while ((w ? ready : rvalid) !== 1'b1 && n < 40)
    begin
      @(negedge clk);
      n++;
    end
    check("answer", 16'(n < 40), 16'h0001);
    if (w) shadow[a] = d;
    else if (shadow.exists(a)) check("rdata", 16'(rdata), exp_byte(a));
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  initial
  begin
    logic [10:0] a;
    logic [10:0] q [$];
    int          n;
    void'($urandom(32'h434bd904));
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    // Corner addresses first, then random, reads mixed in back to back
    for (int i = 0; i < 24; i++)
    begin
      a = (i == 0) ? 11'h000 : (i == 1) ? 11'h7ff : 11'($urandom);
      op(1'b1, a, 8'($urandom));
      q.push_back(a);
      if ($urandom % 2) op(1'b0, q[$urandom % q.size()], 8'h00);
    end
    $display("test random traffic done");
    // Supply loss in mid-write; that byte is forfeit
    while (ready !== 1'b1) @(negedge clk);
    req = 1'b1;
    wr = 1'b1;
    addr = 11'h123;
    @(negedge clk);
    req = 1'b0;
    @(negedge clk);
    sup = 1'b0;
    shadow.delete(11'h123);
    @(negedge clk);
    check("retain", 16'({retain, sel_n, oe}), 16'h0006);
    repeat (8) @(negedge clk);
    sup = 1'b1;
    n = 0;
    while (ready !== 1'b1 && n < 50)
    begin
      @(negedge clk);
      n++;
    end
    check("resume", 16'(n >= asr_pkg::RESUME_CYC && n < 50), 16'h0001);
    // Read cut by supply loss hands back no data
    while (ready !== 1'b1) @(negedge clk);
    req = 1'b1;
    wr = 1'b0;
    @(negedge clk);
    req = 1'b0;
    repeat (2) @(negedge clk);
    sup = 1'b0;
    n = 0;
    repeat (8)
    begin
      @(negedge clk);
      n += rvalid;
    end
    check("cut read", 16'(n), 16'h0000);
    sup = 1'b1;
    $display("test supply loss done");
    foreach (q[i]) op(1'b0, q[i], 8'h00);
    $display("test readback done");
    wrap_up();
  end

  // Run needs well under 2000 cycles
  initial
  begin
    #(25 * 20000);
    errors++;
    wrap_up();
  end
endmodule
